// file: hw/ivp_map.vh
`ifndef IVP_MAP_VH
`define IVP_MAP_VH
// Interrupt numbers; vector address is number times eight
`define IVP_NUM_RESET     5'h1
`define IVP_NUM_STACK     5'h3
`define IVP_NUM_TMR_HI    5'h4
`define IVP_NUM_EXT3      5'h5
`define IVP_NUM_EXT0      5'h8
`define IVP_NUM_AG1_CB    5'hb
`define IVP_NUM_AG2_CB    5'hc
`define IVP_NUM_TMR_LO    5'he
`define IVP_NUM_FIX_OVF   5'hf
`define IVP_NUM_FLT_INV   5'h12
`define IVP_NUM_SW_FIRST  5'h18
`define IVP_VEC_SHIFT     3
// Reserved slots 0,2,9,10,13,19-23 never fire
`define IVP_RESERVED_MASK 32'h00F8_2605
`define IVP_NMI_MASK      32'h0000_0002
`define IVP_RST_LATCH     32'h0000_0000
`define IVP_RST_VECTOR    8'h00
`endif

// file: hw/ivp_prio_enc.v
`timescale 1ns/100ps
`default_nettype none
`include "ivp_map.vh"
module ivp_prio_enc (
  input  wire [31:0] req,
  output reg         any,
  output reg  [4:0]  num
);
  integer i;
  // Scan from the top so the lowest number wins
  always @*
  begin
    any = 1'b0;
    num = 5'h0_0;
    for (i = 31; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        any = 1'b1;
        num = i[4:0];
      end
    end
  end
endmodule // ivp_prio_enc
`default_nettype wire

// file: hw/ivp_vector.v
// Operation
// - Sources numbered 0-31, vector eight times number, lower wins, reset unmaskable.
// - Status, loop stack overflow or program counter stack full vectors to 0x18.
// - High-priority timer option raises timer-zero interrupt at 0x20.
// - Low-priority timer option raises timer-zero at 0x70, below generators.
// - First address generator buffer 7 overflow vectors to 0x58.
// - Second address generator buffer 15 overflow vectors to 0x60.
`timescale 1ns/100ps
`default_nettype none
`include "ivp_map.vh"
module ivp_vector (
  input  wire        clk,
  input  wire        nrst,
  input  wire        ce,
  input  wire        reset_req,
  input  wire        status_stack_ovf,
  input  wire        loop_stack_ovf,
  input  wire        program_counter_stack_full,
  input  wire        timer_zero,
  input  wire        timer_low_prio,
  input  wire [3:0]  external_request_lines,
  input  wire        address_generator1_cb7_ovf,
  input  wire        address_generator2_cb15_ovf,
  input  wire        fix_ovf,
  input  wire        flt_ovf,
  input  wire        flt_unf,
  input  wire        flt_inv,
  input  wire [7:0]  sw_irq,
  input  wire [31:0] mask,
  input  wire        ack,
  output reg         irq_valid,
  output reg  [7:0]  irq_vector,
  output reg  [4:0]  irq_num,
  output reg  [31:0] pending
);
  //////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Vector address of an interrupt number: eight bytes per slot
  function [7:0] ivp_vec_of;
    input [4:0] n;
    begin
      ivp_vec_of = {n, 3'b000};
    end
  endfunction

  // One-hot bit of an interrupt number in the latch
  function [31:0] ivp_bit_of;
    input [4:0] n;
    begin
      ivp_bit_of = 32'h0000_0001 << n;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // External lines come from pins: three stages, a change counts once
  // stages two and three agree, so a single-cycle glitch is dropped.
  // A request must therefore stand for at least two clocks.
  reg  [3:0]  ext_s1_q;
  reg  [3:0]  ext_s2_q;
  reg  [3:0]  ext_s3_q;
  reg  [3:0]  ext_q;
  reg  [3:0]  ext_d;
  integer     k;

  always @*
  begin
    ext_d = ext_q;
    for (k = 0; k < 4; k = k + 1)
    begin
      if (ext_s2_q[k] == ext_s3_q[k])
        ext_d[k] = ext_s3_q[k];
    end
  end

  // A frozen core holds the pin stages too, so no edge is half-seen
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_s1_q <= 4'h0;
      ext_s2_q <= 4'h0;
      ext_s3_q <= 4'h0;
      ext_q    <= 4'h0;
    end
    else if (ce)
    begin
      ext_s1_q <= external_request_lines;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      ext_q    <= ext_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Source conditioning: one line per slot before the latch
  wire        stack_evt;
  wire        tmr_hi_evt;
  wire        tmr_lo_evt;
  wire [3:0]  arith_evt;
  wire [7:0]  sw_evt;

  // Three stack faults share one slot
  assign stack_evt  = status_stack_ovf
                      | loop_stack_ovf
                      | program_counter_stack_full;
  // The option bit steers one timer event to exactly one of two slots
  assign tmr_hi_evt = timer_zero & ~timer_low_prio;
  assign tmr_lo_evt = timer_zero & timer_low_prio;
  // Order: fixed overflow, float overflow, underflow, invalid
  assign arith_evt  = {flt_inv, flt_unf, flt_ovf, fix_ovf};
  assign sw_evt     = sw_irq;

  //////////////////////////////////////////////////////////////////////////
  // Event vector by interrupt number; reserved slots are forced low
  reg  [31:0] evt;

  always @*
  begin
    evt = 32'h0000_0000;
    evt[`IVP_NUM_RESET]        = reset_req;
    evt[`IVP_NUM_STACK]        = stack_evt;
    evt[`IVP_NUM_TMR_HI]       = tmr_hi_evt;
    // Highest external line sits at the lowest number
    evt[`IVP_NUM_EXT3]         = ext_q[3];
    evt[`IVP_NUM_EXT3 + 1]     = ext_q[2];
    evt[`IVP_NUM_EXT3 + 2]     = ext_q[1];
    evt[`IVP_NUM_EXT0]         = ext_q[0];
    evt[`IVP_NUM_AG1_CB]       = address_generator1_cb7_ovf;
    evt[`IVP_NUM_AG2_CB]       = address_generator2_cb15_ovf;
    // Low timer option ranks below generators and external lines
    evt[`IVP_NUM_TMR_LO]       = tmr_lo_evt;
    evt[`IVP_NUM_FIX_OVF]      = arith_evt[0];
    evt[`IVP_NUM_FIX_OVF + 1]  = arith_evt[1];
    evt[`IVP_NUM_FIX_OVF + 2]  = arith_evt[2];
    evt[`IVP_NUM_FLT_INV]      = arith_evt[3];
    evt[`IVP_NUM_SW_FIRST]     = sw_evt[0];
    evt[`IVP_NUM_SW_FIRST + 1] = sw_evt[1];
    evt[`IVP_NUM_SW_FIRST + 2] = sw_evt[2];
    evt[`IVP_NUM_SW_FIRST + 3] = sw_evt[3];
    evt[`IVP_NUM_SW_FIRST + 4] = sw_evt[4];
    evt[`IVP_NUM_SW_FIRST + 5] = sw_evt[5];
    evt[`IVP_NUM_SW_FIRST + 6] = sw_evt[6];
    evt[`IVP_NUM_SW_FIRST + 7] = sw_evt[7];
    evt = evt & ~`IVP_RESERVED_MASK;
  end

  //////////////////////////////////////////////////////////////////////////
  // Latch, pick and present
  reg  [31:0] ack_clr;
  reg  [31:0] pending_d;
  reg         valid_d;
  reg  [4:0]  num_d;
  reg  [7:0]  vector_d;
  wire [31:0] eligible;
  wire        win_any;
  wire [4:0]  win_num;
  wire        ack_hit;
  wire        evt_on_num;
  wire        ack_same;

  // A take only counts while a vector is on offer
  assign ack_hit = ack & irq_valid;

  always @*
  begin
    ack_clr = 32'h0000_0000;
    if (ack_hit)
      ack_clr = ivp_bit_of(irq_num);
  end

  // Reset cannot be masked
  assign eligible = pending & (mask | `IVP_NMI_MASK);

  ivp_prio_enc u_enc (
    .req (eligible),
    .any (win_any),
    .num (win_num)
  );

  // The encoder still sees the bit being taken this edge; hold valid low one
  // cycle rather than offer a vector twice. A fresh event on it re-arms it.
  assign evt_on_num = |(evt & ivp_bit_of(irq_num));
  assign ack_same   = ack_hit & (win_num == irq_num) & ~evt_on_num;

  always @*
  begin
    pending_d = (pending & ~ack_clr) | evt; // set wins over clear
    valid_d   = win_any & ~ack_same;
    num_d     = win_num;
    vector_d  = ivp_vec_of(win_num);
  end

  // Latch: masked bits still latch, they only stay out of the pick
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pending <= `IVP_RST_LATCH;
    end
    else if (ce)
    begin
      pending <= pending_d;
    end
  end

  // Presentation lags the latch by one edge; the sequencer must wait
  // one idle cycle after each take before the next one
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_valid  <= 1'b0;
      irq_num    <= 5'h0_0;
      irq_vector <= `IVP_RST_VECTOR;
    end
    else if (ce)
    begin
      irq_valid  <= valid_d;
      irq_num    <= num_d;
      irq_vector <= vector_d;
    end
  end
endmodule // ivp_vector
`default_nettype wire

// file: dv/ivp_vector_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ivp_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        status_stack_ovf,
  input wire logic        timer_zero,
  input wire logic        timer_low_prio,
  input wire logic        fix_ovf,
  input wire logic        address_generator1_cb7_ovf,
  input wire logic        address_generator2_cb15_ovf,
  input wire logic        irq_valid,
  input wire logic [7:0]  irq_vector,
  input wire logic [4:0]  irq_num,
  input wire logic [31:0] pending
);
  default clocking @(posedge clk); endclocking
  // A frozen core takes nothing, so no obligation runs while ce is low
  default disable iff (!nrst || !ce);
  vec_num_a: assert property (irq_valid |-> irq_vector == {irq_num, 3'h0})
    else $error("vec");
  stk_set_a: assert property (status_stack_ovf |=> pending[3]) else $error("stk");
  tmr_hi_a: assert property (timer_zero && !timer_low_prio |=> pending[4])
    else $error("hi");
  tmr_lo_a: assert property (timer_zero && timer_low_prio |=> pending[14])
    else $error("lo");
  ag1_set_a: assert property (address_generator1_cb7_ovf |=> pending[11]) else $error("ag1");
  ag2_set_a: assert property (address_generator2_cb15_ovf |=> pending[12]) else $error("ag2");
  fix_set_a: assert property (fix_ovf |=> pending[15]) else $error("fix");
  cover property (irq_valid && irq_num == 5'h01);
  cover property (irq_valid && irq_num == 5'h0e);
  cover property (irq_valid && irq_num == 5'h1f);
endmodule // ivp_chk
bind ivp_vector ivp_chk u_chk (.*);
`default_nettype wire

// file: dv/ivp_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module ivp_seq (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic en,
  input  wire logic v,
  output var  logic a_q,
  output var  logic g_q
);
  // Idle cycle after each ack: the vector lags pending by one edge
  always @(posedge clk or negedge nrst)
    if (!nrst) {a_q, g_q} <= 2'h0;
    else {a_q, g_q} <= {en & v & ~a_q & ~g_q, a_q};
endmodule // ivp_seq
`default_nettype wire

// file: dv/ivp_vector_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ivp_vector_tb_top;
  logic clk = 0, nrst = 0, tl = 0, en = 1, c = 1, ack, v;
  logic [4:0] num;
  logic [31:0] pnd;
  logic [22:0] e = '0;
  logic [31:0] m = '1, w = 32'hff07_d9e8;
  logic [7:0] vec;
  int miscompares = 0, samples_checked = 0;
  always #4 clk = ~clk;
  ivp_vector dut (.clk(clk), .nrst(nrst), .ce(c), .reset_req(e[0]), .status_stack_ovf(e[1]),
    .loop_stack_ovf(e[2]), .program_counter_stack_full(e[3]), .timer_zero(e[4]), .mask(m),
    .timer_low_prio(tl), .address_generator1_cb7_ovf(e[5]), .address_generator2_cb15_ovf(e[6]),
    .fix_ovf(e[7]), .flt_ovf(e[8]), .flt_unf(e[9]), .flt_inv(e[10]), .sw_irq(e[22:15]),
    .external_request_lines(e[14:11]), .ack(ack), .irq_valid(v), .irq_vector(vec),
    .irq_num(num), .pending(pnd));
  ivp_seq u_seq (.clk(clk), .nrst(nrst), .en(en), .v(v), .a_q(ack), .g_q());
  task chk(input logic [7:0] a, b);
    samples_checked++;
    if (a !== b) miscompares++;
    if (a !== b) $display("MISMATCH %0t got %h want %h", $time, a, b);
  endtask
  task pul(input logic [22:0] b);
    @(posedge clk) e <= b;
    @(posedge clk) e <= b; // Two edges, so the pin synchroniser takes it
    @(posedge clk) e <= '0;
  endtask
  task wv(input logic [7:0] x);
    @(posedge clk) #1;
    for (int i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk) #1;
    chk(vec, x);
    chk({3'h0, num}, x >> 3);
  endtask
  task s_rst; // Reset must vector with every mask bit off
    m <= '0;
    pul(23'h00_0001);
    wv(8'h08);
    m <= '1;
    pul(23'h00_0010);
    wv(8'h20);
  endtask
  task s_all; // Queue every source but reset, then drain strictly by number
    tl <= 1;
    en <= 0;
    pul(23'h7f_fffe);
    repeat (6) @(posedge clk);
    #1;
    chk(pnd[7:0], w[7:0]);
    chk(pnd[15:8], w[15:8]);
    chk(pnd[23:16], w[23:16]);
    chk(pnd[31:24], w[31:24]);
    c <= 0;
    pul(23'h00_0001);
    #1;
    chk(pnd[7:0], w[7:0]);
    c <= 1;
    en <= 1;
    for (int k = 3; k < 32; k++)
      if (w[k]) wv(8'(k * 8));
  endtask
  task give_verdict;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    s_rst;
    s_all;
    give_verdict;
  end
  initial
  begin
    #20000;
    miscompares++;
    give_verdict;
  end
endmodule // ivp_vector_tb_top
`default_nettype wire
